// [rtl/qspi_pkg.sv]
// Shared constants and types of the quad serial flash read master.
package qspi_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WLEN_W   = 7;   // Word length minus one, 1 to 128 bits.
  localparam int WCNT_W   = 12;  // Word count minus one, 1 to 4096 words.
  localparam int WORD_MAX = 128;
  localparam int CMD_W    = 32;  // Command and address shift register.
  localparam int CLEN_W   = 6;   // Command bit count, 0 to 32.
  localparam int DIV_W    = 8;

  // ----------------------------------------------------------------
  // Fixed settings of the memory-mapped read
  // ----------------------------------------------------------------
  localparam logic [WLEN_W-1:0] MM_WLEN = 7'h1F;  // 32-bit word.
  localparam logic [CLEN_W-1:0] MM_CLEN = 6'h20;  // Opcode plus 24-bit address.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [3:0]       DQ_RST  = 4'h0;

  // Read data lines used per serial clock.
  typedef enum logic [1:0] {
    LINES_SINGLE,
    LINES_DUAL,
    LINES_QUAD
  } lines_t;

  // Wiring of the serial interface.
  typedef enum logic [1:0] {
    PINS_3,
    PINS_4,
    PINS_6
  } pins_t;

endpackage

// [rtl/qspi_read_master.sv]
// Quad serial flash read master with memory-mapped read path.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Always master; drives clock and select.
// - Reads on one, two or four lines.
// - Word length programmable 1 to 128 bits.
// - Word count programmable 1 to 4096.
// - Optional word or frame completion interrupt.
// - Select to first bit delay 0-3 clocks.
// - Clock mode zero, idle low.
// - Read data sampled on falling clock edge.
// - Three, four or six pin wiring.
// - Memory-mapped read without software sequencing.
module qspi_read_master #(
  parameter logic [7:0] MM_OPCODE = 8'h03
) (
  // System clock and reset.
  input  wire logic                          i_mclk,
  input  wire logic                          i_reset,
  // Serial engine clock.
  input  wire logic                          i_lclk,
  // Configuration, held while busy.
  input  wire qspi_pkg::lines_t              i_lines,
  input  wire qspi_pkg::pins_t               i_pins,
  input  wire logic [qspi_pkg::WLEN_W-1:0]   i_word_len,
  input  wire logic [qspi_pkg::WCNT_W-1:0]   i_word_cnt,
  input  wire logic [1:0]                    i_cs_delay,
  input  wire logic [qspi_pkg::DIV_W-1:0]    i_clk_div,
  input  wire logic                          i_word_irq_en,
  input  wire logic                          i_frame_irq_en,
  // Command frame request.
  input  wire logic                          i_start,
  input  wire logic [qspi_pkg::CMD_W-1:0]    i_cmd_data,
  input  wire logic [qspi_pkg::CLEN_W-1:0]   i_cmd_len,
  // Memory-mapped read request.
  input  wire logic                          i_mm_req,
  input  wire logic [23:0]                   i_mm_addr,
  // Results.
  output logic                               o_busy,
  output logic                               o_rx_valid,
  output logic [qspi_pkg::WORD_MAX-1:0]      o_rx_data,
  output logic                               o_mm_ack,
  output logic                               o_word_irq,
  output logic                               o_frame_irq,
  // Serial pins.
  output logic                               o_sclk,
  output logic                               o_cs_n,
  output logic [3:0]                         o_dq_out,
  output logic [3:0]                         o_dq_oe,
  input  wire logic [3:0]                    i_dq_in
);
  import qspi_pkg::*;

  typedef enum {ST_IDLE, ST_CSDLY, ST_CMD, ST_DATA, ST_HOLD, ST_END} st_t;

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  logic                busy_reg, busy_next;
  logic                mm_reg, mm_next;
  logic                req_tgl_reg, req_tgl_next;
  logic                ack_tgl_reg, ack_tgl_next;
  logic                rxv_reg, rxv_next;
  logic                mmack_reg, mmack_next;
  logic                wirq_reg, wirq_next;
  logic                firq_reg, firq_next;
  logic [WORD_MAX-1:0] rxd_reg, rxd_next;
  lines_t              lines_reg, lines_next;
  pins_t               pins_reg, pins_next;
  logic [WLEN_W-1:0]   wlen_reg, wlen_next;
  logic [WCNT_W-1:0]   wcnt_reg, wcnt_next;
  logic [1:0]          dly_reg, dly_next;
  logic [DIV_W-1:0]    div_reg, div_next;
  logic [CMD_W-1:0]    cmd_reg, cmd_next;
  logic [CLEN_W-1:0]   clen_reg, clen_next;
  logic [2:0]          wsync_reg, dsync_reg;
  logic                wordtgl_reg, donetgl_reg;
  logic [WORD_MAX-1:0] hold_reg;  // Word parked by the engine until it is taken.

  // Starts a frame, captures its settings and takes words and frame end.
  always_comb begin
    busy_next    = busy_reg;
    mm_next      = mm_reg;
    req_tgl_next = req_tgl_reg;
    ack_tgl_next = ack_tgl_reg;
    rxd_next     = rxd_reg;
    lines_next   = lines_reg;
    pins_next    = pins_reg;
    wlen_next    = wlen_reg;
    wcnt_next    = wcnt_reg;
    dly_next     = dly_reg;
    div_next     = div_reg;
    cmd_next     = cmd_reg;
    clen_next    = clen_reg;
    rxv_next     = 1'b0;
    mmack_next   = 1'b0;
    wirq_next    = 1'b0;
    firq_next    = 1'b0;
    if (!busy_reg && (i_mm_req || i_start)) begin
      busy_next    = 1'b1;
      req_tgl_next = ~req_tgl_reg;
      pins_next    = i_pins;
      dly_next     = i_cs_delay;
      div_next     = i_clk_div;
      if (i_mm_req) begin
        mm_next    = 1'b1;
        lines_next = LINES_SINGLE;
        wlen_next  = MM_WLEN;
        wcnt_next  = '0;
        cmd_next   = {MM_OPCODE, i_mm_addr};
        clen_next  = MM_CLEN;
      end else begin
        mm_next    = 1'b0;
        lines_next = i_lines;
        wlen_next  = i_word_len;
        wcnt_next  = i_word_cnt;
        cmd_next   = i_cmd_data;
        clen_next  = i_cmd_len;
      end
    end
    // A new word from the engine: hand it out and release the engine.
    if (wsync_reg[2] != wsync_reg[1]) begin
      rxd_next     = hold_reg;  // Held word is stable while its toggle crosses.
      rxv_next     = 1'b1;
      mmack_next   = mm_reg;
      wirq_next    = i_word_irq_en && !mm_reg;
      ack_tgl_next = ~ack_tgl_reg;
    end
    if (dsync_reg[2] != dsync_reg[1]) begin
      busy_next = 1'b0;
      firq_next = i_frame_irq_en && !mm_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      busy_reg    <= 1'b0;
      mm_reg      <= 1'b0;
      req_tgl_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      rxv_reg     <= 1'b0;
      mmack_reg   <= 1'b0;
      wirq_reg    <= 1'b0;
      firq_reg    <= 1'b0;
      rxd_reg     <= '0;
      lines_reg   <= LINES_SINGLE;
      pins_reg    <= PINS_4;
      wlen_reg    <= '0;
      wcnt_reg    <= '0;
      dly_reg     <= '0;
      div_reg     <= DIV_RST;
      cmd_reg     <= '0;
      clen_reg    <= '0;
      wsync_reg   <= '0;
      dsync_reg   <= '0;
    end else begin
      busy_reg    <= busy_next;
      mm_reg      <= mm_next;
      req_tgl_reg <= req_tgl_next;
      ack_tgl_reg <= ack_tgl_next;
      rxv_reg     <= rxv_next;
      mmack_reg   <= mmack_next;
      wirq_reg    <= wirq_next;
      firq_reg    <= firq_next;
      rxd_reg     <= rxd_next;
      lines_reg   <= lines_next;
      pins_reg    <= pins_next;
      wlen_reg    <= wlen_next;
      wcnt_reg    <= wcnt_next;
      dly_reg     <= dly_next;
      div_reg     <= div_next;
      cmd_reg     <= cmd_next;
      clen_reg    <= clen_next;
      wsync_reg   <= {wsync_reg[1:0], wordtgl_reg};
      dsync_reg   <= {dsync_reg[1:0], donetgl_reg};
    end
  end

  // ----------------------------------------------------------------
  // Serial engine domain
  // ----------------------------------------------------------------
  st_t                 st_reg, st_next;
  logic [DIV_W-1:0]    dcnt_reg, dcnt_next;
  logic                sclk_reg, sclk_next;
  logic                csn_reg, csn_next;
  logic [2:0]          dcy_reg, dcy_next;
  logic [CMD_W-1:0]    csh_reg, csh_next;
  logic [CLEN_W-1:0]   cleft_reg, cleft_next;
  logic [WORD_MAX-1:0] rsh_reg, rsh_next;
  logic [WORD_MAX-1:0] hold_next;
  logic [7:0]          bcnt_reg, bcnt_next;
  logic [WCNT_W-1:0]   wleft_reg, wleft_next;
  logic [3:0]          dqo_reg, dqo_next;
  logic [3:0]          dqe_reg, dqe_next;
  logic                wordtgl_next, donetgl_next;
  logic [2:0]          rsync_reg, async_reg;
  logic                tick;
  logic                fall;
  logic [7:0]          step;
  logic [3:0]          idle_oe;

  // Half-period tick of the divided serial clock.
  assign tick = (dcnt_reg == div_reg);
  assign fall = tick && sclk_reg;
  // Bits taken per falling edge.
  assign step = (lines_reg == LINES_QUAD) ? 8'h04 :
                (lines_reg == LINES_DUAL) ? 8'h02 : 8'h01;
  // Hold and write-protect lines are driven high only in six-pin wiring.
  assign idle_oe = (pins_reg == PINS_6) ? 4'hD : 4'h1;

  always_comb begin
    st_next      = st_reg;
    dcnt_next    = tick ? '0 : dcnt_reg + 8'h01;
    sclk_next    = sclk_reg;
    csn_next     = csn_reg;
    dcy_next     = dcy_reg;
    csh_next     = csh_reg;
    cleft_next   = cleft_reg;
    rsh_next     = rsh_reg;
    hold_next    = hold_reg;
    bcnt_next    = bcnt_reg;
    wleft_next   = wleft_reg;
    dqo_next     = dqo_reg;
    dqe_next     = dqe_reg;
    wordtgl_next = wordtgl_reg;
    donetgl_next = donetgl_reg;
    case (st_reg)
      ST_IDLE: begin
        sclk_next = 1'b0;
        csn_next  = 1'b1;
        dqe_next  = DQ_RST;
        if (rsync_reg[2] != rsync_reg[1]) begin
          csn_next   = 1'b0;
          dcy_next   = {dly_reg, 1'b0};
          csh_next   = cmd_reg;
          cleft_next = clen_reg;
          wleft_next = wcnt_reg;
          bcnt_next  = '0;
          rsh_next   = '0;
          dcnt_next  = '0;
          dqo_next   = 4'hC;
          dqe_next   = idle_oe;
          st_next    = ST_CSDLY;
        end
      end
      ST_CSDLY: begin
        // Two half periods per delay clock, serial clock held low.
        if (tick) begin
          if (dcy_reg == 3'h0) begin
            if (cleft_reg == '0) begin
              dqe_next = 4'h0;
              st_next  = ST_DATA;
            end else begin
              dqo_next[0] = csh_reg[CMD_W-1];
              st_next     = ST_CMD;
            end
          end else begin
            dcy_next = dcy_reg - 3'h1;
          end
        end
      end
      ST_CMD: begin
        if (tick) begin
          sclk_next = ~sclk_reg;
        end
        // Next command bit goes out on each falling edge.
        if (fall) begin
          cleft_next = cleft_reg - 6'h01;
          csh_next   = {csh_reg[CMD_W-2:0], 1'b0};
          dqo_next[0] = csh_reg[CMD_W-2];
          if (cleft_reg == 6'h01) begin
            // Single read outside three-pin wiring keeps the idle enables: dq0, plus hold and protect in six-pin.
            dqe_next = (lines_reg == LINES_SINGLE && pins_reg != PINS_3) ?
                       idle_oe : 4'h0;
            st_next  = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (tick) begin
          sclk_next = ~sclk_reg;
        end
        // The flash launches on the previous falling edge.
        if (fall) begin
          case (lines_reg)
            LINES_QUAD: rsh_next = {rsh_reg[WORD_MAX-5:0], i_dq_in};
            LINES_DUAL: rsh_next = {rsh_reg[WORD_MAX-3:0], i_dq_in[1:0]};
            default: rsh_next = {rsh_reg[WORD_MAX-2:0],
                                 (pins_reg == PINS_3) ? i_dq_in[0] : i_dq_in[1]};
          endcase
          bcnt_next = bcnt_reg + step;
          if (bcnt_reg + step > {1'b0, wlen_reg}) begin
            hold_next    = rsh_next;
            wordtgl_next = ~wordtgl_reg;
            st_next      = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        // Clock parked low until the word has been taken.
        dcnt_next = '0;
        if (async_reg[2] != async_reg[1]) begin
          bcnt_next = '0;
          // A clear shift register leaves zeros above the next word.
          rsh_next  = '0;
          if (wleft_reg == '0) begin
            st_next = ST_END;
          end else begin
            wleft_next = wleft_reg - 12'h001;
            st_next    = ST_DATA;
          end
        end
      end
      ST_END: begin
        if (tick) begin
          csn_next     = 1'b1;
          dqe_next     = DQ_RST;
          donetgl_next = ~donetgl_reg;
          st_next      = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_lclk) begin
    if (i_reset) begin
      st_reg      <= ST_IDLE;
      dcnt_reg    <= '0;
      sclk_reg    <= 1'b0;
      csn_reg     <= 1'b1;
      dcy_reg     <= '0;
      csh_reg     <= '0;
      cleft_reg   <= '0;
      rsh_reg     <= '0;
      hold_reg    <= '0;
      bcnt_reg    <= '0;
      wleft_reg   <= '0;
      dqo_reg     <= DQ_RST;
      dqe_reg     <= DQ_RST;
      wordtgl_reg <= 1'b0;
      donetgl_reg <= 1'b0;
      rsync_reg   <= '0;
      async_reg   <= '0;
    end else begin
      st_reg      <= st_next;
      dcnt_reg    <= dcnt_next;
      sclk_reg    <= sclk_next;
      csn_reg     <= csn_next;
      dcy_reg     <= dcy_next;
      csh_reg     <= csh_next;
      cleft_reg   <= cleft_next;
      rsh_reg     <= rsh_next;
      hold_reg    <= hold_next;
      bcnt_reg    <= bcnt_next;
      wleft_reg   <= wleft_next;
      dqo_reg     <= dqo_next;
      dqe_reg     <= dqe_next;
      wordtgl_reg <= wordtgl_next;
      donetgl_reg <= donetgl_next;
      rsync_reg   <= {rsync_reg[1:0], req_tgl_reg};
      async_reg   <= {async_reg[1:0], ack_tgl_reg};
    end
  end

  // Outputs straight from flip-flops.
  assign o_busy      = busy_reg;
  assign o_rx_valid  = rxv_reg;
  assign o_rx_data   = rxd_reg;
  assign o_mm_ack    = mmack_reg;
  assign o_word_irq  = wirq_reg;
  assign o_frame_irq = firq_reg;
  assign o_sclk      = sclk_reg;
  assign o_cs_n      = csn_reg;
  assign o_dq_out    = dqo_reg;
  assign o_dq_oe     = dqe_reg;

endmodule

`default_nettype wire

// [tb/qspi_read_master_checker.sv]
// Concurrent checks on the ports of the quad serial flash read master.
`timescale 1ns/10ps
`default_nettype none
module qspi_read_master_checker (
  // Clocks and reset.
  input wire logic                       i_mclk,
  input wire logic                       i_reset,
  input wire logic                       i_lclk,
  // Configuration and requests.
  input wire qspi_pkg::pins_t            i_pins,
  input wire logic [qspi_pkg::DIV_W-1:0] i_clk_div,
  input wire logic                       i_word_irq_en,
  input wire logic                       i_frame_irq_en,
  input wire logic                       i_start,
  input wire logic                       i_mm_req,
  // Results and pins.
  input wire logic                       o_busy,
  input wire logic                       o_rx_valid,
  input wire logic [127:0]               o_rx_data,
  input wire logic                       o_mm_ack,
  input wire logic                       o_word_irq,
  input wire logic                       o_frame_irq,
  input wire logic                       o_sclk,
  input wire logic                       o_cs_n,
  input wire logic [3:0]                 o_dq_oe
);
  import qspi_pkg::*;
  logic [8:0] hi_cnt_reg;
  logic [8:0] hi_cnt_next;
  // Counts link cycles spent with the serial clock high.
  always_comb hi_cnt_next = o_sclk ? hi_cnt_reg + 9'h001 : 9'h000;
  always_ff @(posedge i_lclk) begin
    if (i_reset)
      hi_cnt_reg <= 9'h000;
    else
      hi_cnt_reg <= hi_cnt_next;
  end
  a_sclk_idle_low: assert property (@(posedge i_lclk) disable iff (i_reset)
    o_cs_n |-> !o_sclk) else $error("serial clock high while deselected");
  a_sclk_high_len: assert property (@(posedge i_lclk) disable iff (i_reset)
    $fell(o_sclk) |-> hi_cnt_reg == {1'b0, i_clk_div} + 9'h001)
    else $error("serial clock high phase has wrong length");
  a_idle_no_drive: assert property (@(posedge i_lclk) disable iff (i_reset)
    o_cs_n |-> o_dq_oe == 4'h0) else $error("lines driven while deselected");
  a_upper_lines: assert property (@(posedge i_lclk) disable iff (i_reset)
    i_pins != PINS_6 |-> o_dq_oe[3:2] == 2'h0) else $error("upper lines driven");
  a_three_pin: assert property (@(posedge i_lclk) disable iff (i_reset)
    i_pins == PINS_3 |-> !o_dq_oe[1]) else $error("line one driven in 3-pin");
  a_busy_on_req: assert property (@(posedge i_mclk) disable iff (i_reset)
    !o_busy && (i_start || i_mm_req) |=> o_busy) else $error("request not taken");
  a_busy_covers_cs: assert property (@(posedge i_mclk) disable iff (i_reset)
    !o_cs_n |-> o_busy) else $error("select active while idle");
  a_rx_one_cycle: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rx_valid |=> !o_rx_valid) else $error("word strobe too long");
  a_rx_data_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    !o_rx_valid |-> $stable(o_rx_data)) else $error("word data changed");
  a_mm_ack_word: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_mm_ack |-> o_rx_valid) else $error("mapped ack without word");
  a_frame_irq_end: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_frame_irq |-> i_frame_irq_en && !o_busy && $past(o_busy))
    else $error("frame pulse misplaced");
  a_word_irq_en: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_word_irq |-> i_word_irq_en) else $error("word pulse while disabled");
endmodule
bind qspi_read_master qspi_read_master_checker u_checker (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_lclk(i_lclk), .i_pins(i_pins),
  .i_clk_div(i_clk_div), .i_word_irq_en(i_word_irq_en), .i_frame_irq_en(i_frame_irq_en),
  .i_start(i_start), .i_mm_req(i_mm_req), .o_busy(o_busy), .o_rx_valid(o_rx_valid),
  .o_rx_data(o_rx_data), .o_mm_ack(o_mm_ack), .o_word_irq(o_word_irq),
  .o_frame_irq(o_frame_irq), .o_sclk(o_sclk), .o_cs_n(o_cs_n), .o_dq_oe(o_dq_oe));
`default_nettype wire

// [tb/qspi_flash_model.sv]
// Behavioural serial flash that answers reads from a fixed bit pattern.
`timescale 1ns/10ps
`default_nettype none
module qspi_flash_model #(
  parameter logic [127:0] PATTERN = 128'h0
) (
  // Serial pins from the master.
  input  wire logic             i_sclk,
  input  wire logic             i_cs_n,
  // Command bits that come before the read data.
  input  wire logic [5:0]       i_cmd_bits,
  // Read width the master is set to.
  input  wire qspi_pkg::lines_t i_lines,
  input  wire qspi_pkg::pins_t  i_pins,
  // Levels the flash puts on the lines.
  output logic [3:0]            o_dq
);
  import qspi_pkg::*;
  int           ptr;
  int           nfall;
  logic [127:0] sh;
  initial o_dq = 4'h5;
  // A frame reads from the top of the pattern; released lines keep flipping.
  always @(negedge i_cs_n) begin
    ptr = 0;
    nfall = 0;
  end
  always @(posedge i_cs_n) o_dq = ~o_dq;
  // The first unit launches on the fall that ends the command, then one per fall.
  always @(negedge i_sclk) begin
    if (!i_cs_n) begin
      nfall++;
      #1.5;
      sh = PATTERN << ptr;
      o_dq = ~o_dq;
      if (nfall >= int'(i_cmd_bits)) begin
        if (i_lines == LINES_QUAD) begin
          o_dq = sh[127:124];
          ptr += 4;
        end else if (i_lines == LINES_DUAL) begin
          o_dq[1:0] = sh[127:126];
          ptr += 2;
        end else begin
          if (i_pins == PINS_3)
            o_dq[0] = sh[127];
          else
            o_dq[1] = sh[127];
          ptr += 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [tb/quad_serial_flash_read_master_bench.sv]
// Self-checking bench for the quad serial flash read master.
`timescale 1ns/10ps
`default_nettype none
module quad_serial_flash_read_master_bench;
  import qspi_pkg::*;
  localparam logic [127:0] PAT = 128'hC3A5_0F96_7E18_D24B_5AF0_3C69_E187_B42D;
  localparam logic [31:0]  CMD_WORD = 32'hEB00_0000;
  localparam logic [7:0]   MM_OP    = 8'h03;
  logic         i_mclk, i_reset, i_lclk, i_word_irq_en, i_frame_irq_en, i_start, i_mm_req;
  logic         o_busy, o_rx_valid, o_mm_ack, o_word_irq, o_frame_irq, o_sclk, o_cs_n;
  lines_t       i_lines;
  pins_t        i_pins;
  logic [6:0]   i_word_len;
  logic [11:0]  i_word_cnt;
  logic [1:0]   i_cs_delay;
  logic [7:0]   i_clk_div;
  logic [23:0]  i_mm_addr;
  logic [127:0] o_rx_data;
  logic [3:0]   o_dq_out, o_dq_oe, i_dq_in, flash_dq;
  logic [5:0]   cmd_len;
  logic [31:0]  cmd_seen;
  int           miscompares, n_compared, n_wirq, n_firq, n_ack, lc, rise_at, r0, n_rise;
  bit           seen;
  logic [127:0] rxq[$];
  // Each line shows whoever drives it.
  assign i_dq_in = (o_dq_oe & o_dq_out) | (~o_dq_oe & flash_dq);
  qspi_read_master #(.MM_OPCODE(MM_OP)) dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_lclk(i_lclk), .i_lines(i_lines),
    .i_pins(i_pins), .i_word_len(i_word_len), .i_word_cnt(i_word_cnt),
    .i_cs_delay(i_cs_delay), .i_clk_div(i_clk_div), .i_word_irq_en(i_word_irq_en),
    .i_frame_irq_en(i_frame_irq_en), .i_start(i_start), .i_cmd_data(CMD_WORD),
    .i_cmd_len(cmd_len), .i_mm_req(i_mm_req), .i_mm_addr(i_mm_addr), .o_busy(o_busy),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_mm_ack(o_mm_ack),
    .o_word_irq(o_word_irq), .o_frame_irq(o_frame_irq), .o_sclk(o_sclk),
    .o_cs_n(o_cs_n), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
  qspi_flash_model #(.PATTERN(PAT)) flash (
    .i_sclk(o_sclk), .i_cs_n(o_cs_n), .i_cmd_bits(cmd_len), .i_lines(i_lines),
    .i_pins(i_pins), .o_dq(flash_dq));
  // Clocks of unrelated phase.
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    i_lclk = 1'b0;
    #1.3;
    forever #3 i_lclk = ~i_lclk;
  end
  // Collects words and pulses.
  always @(posedge i_mclk) begin
    if (o_rx_valid === 1'b1)
      rxq.push_back(o_rx_data);
    if (o_mm_ack === 1'b1)
      n_ack++;
    if (o_word_irq === 1'b1)
      n_wirq++;
    if (o_frame_irq === 1'b1)
      n_firq++;
  end
  // Records the command bits that the flash sees on dq0 at each rising edge.
  always @(negedge o_cs_n)
    n_rise = 0;
  always @(posedge o_sclk) begin
    if (o_cs_n === 1'b0 && n_rise < int'(cmd_len))
      cmd_seen = {cmd_seen[30:0], i_dq_in[0]};
    n_rise++;
  end
  // Measures link cycles from select to the first serial clock rise.
  always @(posedge i_lclk) begin
    if (o_cs_n === 1'b1) begin
      lc = 0;
      seen = 1'b0;
    end else if (!seen) begin
      lc++;
      if (o_sclk === 1'b1) begin
        seen = 1'b1;
        rise_at = lc;
      end
    end
  end
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_idle;
    int t;
    for (t = 0; t < 20000 && o_busy !== 1'b0; t++)
      @(negedge i_mclk);
    // One more cycle lets the collector count the frame-end pulse.
    @(negedge i_mclk);
    if (t == 20000) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // One command frame; a second start while busy must be ignored.
  task automatic run(input lines_t ln, input pins_t pn, input int len, input int cnt,
                     input logic [1:0] dly, input logic [7:0] div, input logic we,
                     input logic fe);
    @(negedge i_mclk);
    i_lines = ln;
    i_pins = pn;
    i_word_len = 7'(len - 1);
    i_word_cnt = 12'(cnt - 1);
    i_cs_delay = dly;
    i_clk_div = div;
    i_word_irq_en = we;
    i_frame_irq_en = fe;
    rxq.delete();
    n_wirq = 0;
    n_firq = 0;
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_start = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    wait_idle();
    check("words", 128'(cnt), 128'(rxq.size()));
    for (int i = 0; i < rxq.size(); i++)
      check("word", (PAT << (i * len)) >> (128 - len), rxq[i]);
    check("word_irq", we ? 128'(cnt) : 128'(0), 128'(n_wirq));
    check("frame_irq", 128'(fe), 128'(n_firq));
    check("cmd", 128'(CMD_WORD[31:24]), 128'(cmd_seen[7:0]));
  endtask
  initial begin
    {i_reset, i_word_irq_en, i_frame_irq_en, i_start, i_mm_req} = 5'h10;
    {i_word_len, i_word_cnt, i_cs_delay, i_clk_div, i_mm_addr} = '0;
    i_lines = LINES_SINGLE;
    i_pins = PINS_4;
    cmd_len = 6'h08;
    repeat (10) @(negedge i_mclk);
    i_reset = 1'b0;
    run(LINES_SINGLE, PINS_4, 8, 4, 2'h0, 8'h01, 1'b1, 1'b1);
    r0 = rise_at;
    run(LINES_DUAL, PINS_4, 16, 2, 2'h3, 8'h01, 1'b0, 1'b1);
    check("cs_delay", 128'(12), 128'(rise_at - r0));
    run(LINES_SINGLE, PINS_3, 1, 3, 2'h2, 8'h02, 1'b1, 1'b0);
    run(LINES_QUAD, PINS_6, 128, 1, 2'h1, 8'h00, 1'b0, 1'b0);
    // Mapped read wins over a start raised in the same cycle.
    @(negedge i_mclk);
    i_lines = LINES_SINGLE;
    i_pins = PINS_4;
    rxq.delete();
    n_ack = 0;
    cmd_len = MM_CLEN;
    i_mm_addr = 24'h3C5A96;
    i_mm_req = 1'b1;
    i_start = 1'b1;
    @(negedge i_mclk);
    i_mm_req = 1'b0;
    i_start = 1'b0;
    wait_idle();
    check("mm_ack", 128'(1), 128'(n_ack));
    check("mm_words", 128'(1), 128'(rxq.size()));
    check("mm_word", PAT >> 96, rxq[0]);
    check("mm_cmd", 128'({MM_OP, 24'h3C5A96}), 128'(cmd_seen));
    print_verdict();
  end
endmodule
`default_nettype wire
